// File: hw/adc_cal_pkg.sv
package adc_cal_pkg;

    // ------------------------------------------------------------
    // Core and channel geometry
    // ------------------------------------------------------------
    localparam int unsigned CORE_COUNT  = 6;
    localparam int unsigned INPUT_COUNT = 4;
    localparam int unsigned SAMPLE_W    = 12;
    localparam int unsigned CORE_IDX_W  = 3;
    localparam int unsigned CNT_W       = 24;

    // Two's-complement mid-scale code shown while foreground calibration runs
    localparam logic [SAMPLE_W-1:0] MID_SCALE_CODE = 12'h000;

    // Foreground core per input: A, B, C, D
    localparam logic [CORE_IDX_W-1:0] FG_CORE_A = 3'h0;
    localparam logic [CORE_IDX_W-1:0] FG_CORE_B = 3'h1;
    localparam logic [CORE_IDX_W-1:0] FG_CORE_C = 3'h4;
    localparam logic [CORE_IDX_W-1:0] FG_CORE_D = 3'h5;
    // Spare cores: bank 0 serves A/B, bank 1 serves C/D
    localparam logic [CORE_IDX_W-1:0] SPARE_CORE_0 = 3'h2;
    localparam logic [CORE_IDX_W-1:0] SPARE_CORE_1 = 3'h3;

    // ------------------------------------------------------------
    // Register map (15-bit address, 8-bit data)
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 15;
    localparam int unsigned DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CORE_SRC_DLY = 15'h009A;
    localparam logic [ADDR_W-1:0] ADDR_OUTPUT_MUX_SWITCH_DELAY  = 15'h009B;
    localparam logic [ADDR_W-1:0] ADDR_OFS_TRIM     = 15'h0100;  // + core 0..5
    localparam logic [ADDR_W-1:0] ADDR_GAIN_TRIM    = 15'h0110;  // + core 0..5
    localparam logic [ADDR_W-1:0] ADDR_TERM_TRIM    = 15'h0120;  // + input 0..3
    localparam logic [DATA_W-1:0] RST_CORE_SRC_DLY  = 8'h00;
    localparam logic [DATA_W-1:0] RST_OUTPUT_MUX_SWITCH_DELAY   = 8'h00;
    localparam logic [DATA_W-1:0] READ_ZERO         = 8'h00;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_FG_CAL = 3'b000,
        ST_RUN    = 3'b001,
        ST_SLEEP  = 3'b010,
        ST_WAKE   = 3'b011,
        ST_BG_CAL = 3'b100,
        ST_HOLD   = 3'b101,
        ST_SWAP   = 3'b110
    } cal_state_t;

endpackage

// File: hw/adc_calibration_sequencer.sv
module adc_calibration_sequencer #(
    parameter int unsigned              FG_CAL_CYCLES     = 8192,
    parameter int unsigned              BG_CAL_CYCLES     = 8192,
    parameter int unsigned              SLEEP_UNIT_CYCLES = 256,
    parameter int unsigned              WAKE_UNIT_CYCLES  = 16,
    parameter logic [7:0]               FACTORY_OFS_TRIM  = 8'h80,
    parameter logic [7:0]               FACTORY_GAIN_TRIM = 8'h80,
    parameter logic [7:0]               FACTORY_TERM_TRIM = 8'h80
) (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // Calibration control bits
    input  wire logic                   triggerPinSelect,
    input  wire logic                   softwareCalibrationTrigger,
    input  wire logic                   calibrationTriggerPin,
    input  wire logic                   backgroundCalibrationEnable,
    input  wire logic                   lowPowerBackgroundEnable,
    input  wire logic                   manualSpareControl,
    input  wire logic [7:0]             spareSleepInterval,
    input  wire logic [7:0]             spareWakeSettleTime,
    input  wire logic                   statusPinSelect,
    input  wire logic                   oneShotOffsetCalibration,
    input  wire logic                   continuousOffsetCalibration,
    // Register access port
    input  wire logic                   regWrEn,
    input  wire logic                   regRdEn,
    input  wire logic [14:0]            regAddr,
    input  wire logic [7:0]             regWrData,
    output logic      [7:0]             regRdData,
    // Converter cores
    input  wire logic [71:0]            coreSamples,
    input  wire logic [47:0]            offsetEstimate,
    output logic      [47:0]            channelData,
    output logic      [5:0]             corePowerDown,
    output logic      [5:0]             coreCalibrating,
    output logic      [11:0]            inputSourceMap,
    output logic                        foregroundBusy,
    output logic                        spareCalibratedFlag,
    output logic                        calibrationStatusPin
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // One-hot mask of a core index
    function automatic logic [5:0] coreMask(input logic [2:0] idx);
        coreMask = 6'h01 << idx;
    endfunction

    // Pick one 12-bit sample out of the flat core bus
    function automatic logic [11:0] coreWord(input logic [71:0] flat, input logic [2:0] idx);
        coreWord = flat[idx*adc_cal_pkg::SAMPLE_W +: adc_cal_pkg::SAMPLE_W];
    endfunction

    localparam logic [23:0] FG_CYC   = 24'(FG_CAL_CYCLES);
    localparam logic [23:0] BG_CYC   = 24'(BG_CAL_CYCLES);
    localparam logic [15:0] SLP_UNIT = 16'(SLEEP_UNIT_CYCLES);
    localparam logic [15:0] WAK_UNIT = 16'(WAKE_UNIT_CYCLES);

    adc_cal_pkg::cal_state_t state_r;
    adc_cal_pkg::cal_state_t state_nxt;

    logic [23:0] cnt_r;
    logic [2:0]  srcCore_r [4];
    logic [2:0]  spare_r   [2];
    logic [1:0]  nextIn_r;
    logic        bank_r;
    logic        trigMeta_r;
    logic        trigSync_r;
    logic        trigPrev_r;
    logic        spareDone_r;
    logic [7:0]  coreSrcDly_r;
    logic [7:0]  muxSelDly_r;
    logic [7:0]  ofsTrim_r  [6];
    logic [7:0]  gainTrim_r [6];
    logic [7:0]  termTrim_r [4];

    // Selected trigger; pin side only after the synchroniser
    wire calibration_trigger_pin   = triggerPinSelect ? trigSync_r : softwareCalibrationTrigger;

    // ------------------------------------------------------------
    // Trigger selection
    // ------------------------------------------------------------
    // Two-stage synchroniser; only the second stage is used
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            trigMeta_r <= 1'b0;
            trigSync_r <= 1'b0;
            trigPrev_r <= 1'b0;
        end
        else
        begin
            trigMeta_r <= calibrationTriggerPin;
            trigSync_r <= trigMeta_r;
            trigPrev_r <= calibration_trigger_pin;
        end
    end

    wire trigRise  = calibration_trigger_pin && !trigPrev_r;
    // Background rotation requires the software trigger held high, except that
    // manual low-power control toggles that trigger and must not stop rotation
    wire bgActive  = backgroundCalibrationEnable && !triggerPinSelect
                     && (softwareCalibrationTrigger
                         || (lowPowerBackgroundEnable && manualSpareControl));
    wire lowPower  = bgActive && lowPowerBackgroundEnable;
    wire manualLp  = lowPower && manualSpareControl;

    // ------------------------------------------------------------
    // Sequencer timing targets
    // ------------------------------------------------------------
    wire [23:0] sleepTarget = 24'(spareSleepInterval * SLP_UNIT);
    wire [23:0] wakeTarget  = 24'(spareWakeSettleTime * WAK_UNIT);
    // Larger of the two delays governs when the swap completes
    wire [7:0]  swapTarget  = (coreSrcDly_r > muxSelDly_r) ? coreSrcDly_r : muxSelDly_r;
    wire        fgEnd       = (state_r == adc_cal_pkg::ST_FG_CAL) && (cnt_r >= FG_CYC);
    wire        bgEnd       = (state_r == adc_cal_pkg::ST_BG_CAL) && (cnt_r >= BG_CYC);
    wire        swapEnd     = (state_r == adc_cal_pkg::ST_SWAP) && (cnt_r >= 24'(swapTarget));
    wire [1:0]  swapIn      = {bank_r, nextIn_r[bank_r]};

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            adc_cal_pkg::ST_FG_CAL:
                if (fgEnd)
                    state_nxt = adc_cal_pkg::ST_RUN;
            adc_cal_pkg::ST_RUN:
                if (bgActive)
                    state_nxt = lowPower ? adc_cal_pkg::ST_SLEEP : adc_cal_pkg::ST_BG_CAL;
                else if (trigRise)
                    state_nxt = adc_cal_pkg::ST_FG_CAL;
            adc_cal_pkg::ST_SLEEP:
                if (!bgActive)
                    state_nxt = adc_cal_pkg::ST_RUN;
                else if (!lowPower)
                    state_nxt = adc_cal_pkg::ST_BG_CAL;
                else if (manualLp ? !calibration_trigger_pin : (cnt_r >= sleepTarget))
                    state_nxt = adc_cal_pkg::ST_WAKE;
            adc_cal_pkg::ST_WAKE:
                if (cnt_r >= wakeTarget)
                    state_nxt = adc_cal_pkg::ST_BG_CAL;
            adc_cal_pkg::ST_BG_CAL:
                if (bgEnd)
                    state_nxt = adc_cal_pkg::ST_HOLD;
            adc_cal_pkg::ST_HOLD:
                // Manual mode keeps the spare powered until the trigger is high
                if (!manualLp || calibration_trigger_pin)
                    state_nxt = adc_cal_pkg::ST_SWAP;
            adc_cal_pkg::ST_SWAP:
                if (swapEnd)
                    state_nxt = !bgActive ? adc_cal_pkg::ST_RUN
                              : lowPower ? adc_cal_pkg::ST_SLEEP
                              : adc_cal_pkg::ST_BG_CAL;
            default:
                state_nxt = adc_cal_pkg::ST_FG_CAL;
        endcase
    end

    // ------------------------------------------------------------
    // State, counter and core rotation
    // ------------------------------------------------------------
    // Reset lands in foreground calibration so power-up always calibrates
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= adc_cal_pkg::ST_FG_CAL;
            cnt_r   <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r   <= (state_nxt != state_r) ? 24'h000000 : cnt_r + 24'h000001;
        end
    end

    // Spare takes the displaced core's slot; displaced core is calibrated after the other bank's pass
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            srcCore_r[0] <= adc_cal_pkg::FG_CORE_A;
            srcCore_r[1] <= adc_cal_pkg::FG_CORE_B;
            srcCore_r[2] <= adc_cal_pkg::FG_CORE_C;
            srcCore_r[3] <= adc_cal_pkg::FG_CORE_D;
            spare_r[0]   <= adc_cal_pkg::SPARE_CORE_0;
            spare_r[1]   <= adc_cal_pkg::SPARE_CORE_1;
            nextIn_r     <= 2'h0;
            bank_r       <= 1'b0;
        end
        else if (swapEnd)
        begin
            srcCore_r[swapIn]  <= spare_r[bank_r];
            spare_r[bank_r]    <= srcCore_r[swapIn];
            nextIn_r[bank_r]   <= !nextIn_r[bank_r];
            bank_r             <= !bank_r;
        end
    end

    // Spare-calibrated flag: set at end of a pass, cleared when the swap starts
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            spareDone_r <= 1'b0;
        else if (bgEnd)
            spareDone_r <= 1'b1;
        else if (state_r == adc_cal_pkg::ST_SWAP || state_r == adc_cal_pkg::ST_FG_CAL)
            spareDone_r <= 1'b0;
    end

    // ------------------------------------------------------------
    // Core power and calibration indication
    // ------------------------------------------------------------
    wire inFg      = (state_r == adc_cal_pkg::ST_FG_CAL);
    wire spareBusy = (state_r == adc_cal_pkg::ST_WAKE) || (state_r == adc_cal_pkg::ST_BG_CAL)
                     || (state_r == adc_cal_pkg::ST_HOLD) || (state_r == adc_cal_pkg::ST_SWAP);
    wire [5:0] spareMask  = coreMask(spare_r[0]) | coreMask(spare_r[1]);
    wire [5:0] activeSpr  = coreMask(spare_r[bank_r]);
    // Only one spare is ever awake in low-power mode, and only while due
    wire [5:0] pwrDownNxt = inFg ? 6'h00
                          : !bgActive ? spareMask
                          : lowPower ? (spareMask & ~(spareBusy ? activeSpr : 6'h00))
                          : 6'h00;
    // Foreground takes all cores offline; background calibrates one spare
    wire [5:0] calNxt     = inFg ? 6'h3F
                          : (state_r == adc_cal_pkg::ST_BG_CAL) ? activeSpr
                          : 6'h00;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            corePowerDown        <= 6'h00;
            coreCalibrating      <= 6'h3F;
            foregroundBusy       <= 1'b1;
            calibrationStatusPin <= 1'b0;
        end
        else
        begin
            corePowerDown        <= pwrDownNxt;
            coreCalibrating      <= calNxt;
            foregroundBusy       <= inFg;
            // Select 0 shows foreground done instead
            calibrationStatusPin <= statusPinSelect ? spareDone_r : !inFg;
        end
    end

    assign spareCalibratedFlag = spareDone_r;
    assign inputSourceMap      = {srcCore_r[3], srcCore_r[2], srcCore_r[1], srcCore_r[0]};

    // ------------------------------------------------------------
    // Output sample mux
    // ------------------------------------------------------------
    // Mid-scale stands in while cores are offline, avoiding garbage samples
    for (genvar ch = 0; ch < adc_cal_pkg::INPUT_COUNT; ch++)
    begin : g_chan
        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
                channelData[ch*12 +: 12] <= adc_cal_pkg::MID_SCALE_CODE;
            else if (inFg)
                channelData[ch*12 +: 12] <= adc_cal_pkg::MID_SCALE_CODE;
            else
                channelData[ch*12 +: 12] <= coreWord(coreSamples, srcCore_r[ch]);
        end
    end

    // ------------------------------------------------------------
    // Register file and trims
    // ------------------------------------------------------------
    wire [14:0] ofsOff  = regAddr - adc_cal_pkg::ADDR_OFS_TRIM;
    wire [14:0] gainOff = regAddr - adc_cal_pkg::ADDR_GAIN_TRIM;
    wire [14:0] termOff = regAddr - adc_cal_pkg::ADDR_TERM_TRIM;
    wire        hitOfs  = (ofsOff  < 15'(adc_cal_pkg::CORE_COUNT));
    wire        hitGain = (gainOff < 15'(adc_cal_pkg::CORE_COUNT));
    wire        hitTerm = (termOff < 15'(adc_cal_pkg::INPUT_COUNT));
    wire        hitSrc  = (regAddr == adc_cal_pkg::ADDR_CORE_SRC_DLY);
    wire        hitMux  = (regAddr == adc_cal_pkg::ADDR_OUTPUT_MUX_SWITCH_DELAY);
    wire        fgOfsLoad = fgEnd && oneShotOffsetCalibration;
    wire        bgOfsLoad = bgEnd && continuousOffsetCalibration;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            coreSrcDly_r <= adc_cal_pkg::RST_CORE_SRC_DLY;
            muxSelDly_r  <= adc_cal_pkg::RST_OUTPUT_MUX_SWITCH_DELAY;
        end
        else if (regWrEn)
        begin
            if (hitSrc)
                coreSrcDly_r <= regWrData;
            if (hitMux)
                muxSelDly_r  <= regWrData;
        end
    end

    // Engine corrections win over a host write to the same trim
    for (genvar c = 0; c < adc_cal_pkg::CORE_COUNT; c++)
    begin : g_core_trim
        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                ofsTrim_r[c]  <= FACTORY_OFS_TRIM;
                gainTrim_r[c] <= FACTORY_GAIN_TRIM;
            end
            else
            begin
                if (fgOfsLoad || (bgOfsLoad && spare_r[bank_r] == 3'(c)))
                    ofsTrim_r[c] <= offsetEstimate[c*8 +: 8];
                else if (regWrEn && hitOfs && ofsOff[2:0] == 3'(c))
                    ofsTrim_r[c] <= regWrData;
                if (regWrEn && hitGain && gainOff[2:0] == 3'(c))
                    gainTrim_r[c] <= regWrData;
            end
        end
    end

    for (genvar t = 0; t < adc_cal_pkg::INPUT_COUNT; t++)
    begin : g_term_trim
        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
                termTrim_r[t] <= FACTORY_TERM_TRIM;
            else if (regWrEn && hitTerm && termOff[1:0] == 2'(t))
                termTrim_r[t] <= regWrData;
        end
    end

    // Read data registered; unmapped addresses read zero
    wire [7:0] rdMux = hitSrc  ? coreSrcDly_r
                     : hitMux  ? muxSelDly_r
                     : hitOfs  ? ofsTrim_r[ofsOff[2:0]]
                     : hitGain ? gainTrim_r[gainOff[2:0]]
                     : hitTerm ? termTrim_r[termOff[1:0]]
                     : adc_cal_pkg::READ_ZERO;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            regRdData <= adc_cal_pkg::READ_ZERO;
        else if (regRdEn)
            regRdData <= rdMux;
    end

endmodule // adc_calibration_sequencer

// File: bench/adc_cal_props.sv
module adc_cal_props #(
    parameter int unsigned FG_CAL_CYCLES = 8192
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        triggerPinSelect,
    input  wire logic        softwareCalibrationTrigger,
    input  wire logic        calibrationTriggerPin,
    input  wire logic        backgroundCalibrationEnable,
    input  wire logic        lowPowerBackgroundEnable,
    input  wire logic        manualSpareControl,
    input  wire logic        statusPinSelect,
    input  wire logic [47:0] channelData,
    input  wire logic [5:0]  corePowerDown,
    input  wire logic [5:0]  coreCalibrating,
    input  wire logic [11:0] inputSourceMap,
    input  wire logic        foregroundBusy,
    input  wire logic        spareCalibratedFlag,
    input  wire logic        calibrationStatusPin
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // Helper logic
    // ----------------------------------------
    // Rotation is live only with the software trigger set up for it
    wire logic bgOn = backgroundCalibrationEnable && !triggerPinSelect
                      && (softwareCalibrationTrigger || (lowPowerBackgroundEnable && manualSpareControl));
    wire logic idle = !foregroundBusy && !spareCalibratedFlag && coreCalibrating == 6'h00
                      && !backgroundCalibrationEnable && !lowPowerBackgroundEnable;
    logic [15:0] busyLen_r;
    // Busy run length; a counter because the run is far beyond a repetition
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            busyLen_r <= 16'h0000;
        else
            busyLen_r <= foregroundBusy ? busyLen_r + 16'h0001 : 16'h0000;
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    fg_mid_code_a: assert property (foregroundBusy && $past(foregroundBusy) |-> channelData == 48'h0)
        else $error("output not mid-scale during foreground calibration");
    one_cal_core_a: assert property (bgOn && !foregroundBusy && !$past(foregroundBusy) |-> $onehot0(coreCalibrating))
        else $error("more than one core calibrating");
    cal_powered_a: assert property (coreCalibrating != 6'h00 |-> (coreCalibrating & corePowerDown) == 6'h00)
        else $error("calibrating core is powered down");
    spare_bank_a: assert property (inputSourceMap[2:0] <= 3'h2 && inputSourceMap[5:3] <= 3'h2
        && inputSourceMap[2:0] != inputSourceMap[5:3] && inputSourceMap[8:6] >= 3'h3 && inputSourceMap[11:9] >= 3'h3
        && inputSourceMap[8:6] <= 3'h5 && inputSourceMap[11:9] <= 3'h5 && inputSourceMap[8:6] != inputSourceMap[11:9])
        else $error("core map leaves its bank");
    status_pin_a: assert property (statusPinSelect && $rose(spareCalibratedFlag) |-> ##[0:1] calibrationStatusPin)
        else $error("status pin missed spare completion");
    hold_swap_a: assert property (lowPowerBackgroundEnable && manualSpareControl && spareCalibratedFlag
        && !triggerPinSelect && !softwareCalibrationTrigger |=> $stable(inputSourceMap))
        else $error("swap while trigger low");
    soft_trig_a: assert property (idle && !triggerPinSelect && $rose(softwareCalibrationTrigger) |-> ##[1:4] foregroundBusy)
        else $error("software trigger did not start calibration");
    pin_trig_a: assert property (idle && triggerPinSelect && $rose(calibrationTriggerPin) |-> ##[2:6] foregroundBusy)
        else $error("pin trigger did not start calibration");
    fg_length_a: assert property ($fell(foregroundBusy) |-> busyLen_r >= FG_CAL_CYCLES + 1 && busyLen_r <= FG_CAL_CYCLES + 3)
        else $error("foreground calibration length wrong");
    cover property ($fell(foregroundBusy));
    cover property ($rose(spareCalibratedFlag));
    cover property ($changed(inputSourceMap));
endmodule // adc_cal_props

bind adc_calibration_sequencer adc_cal_props #(.FG_CAL_CYCLES(FG_CAL_CYCLES)) adc_cal_props_i (.clk(clk), .rst_n(rst_n),
    .triggerPinSelect(triggerPinSelect), .softwareCalibrationTrigger(softwareCalibrationTrigger),
    .calibrationTriggerPin(calibrationTriggerPin), .backgroundCalibrationEnable(backgroundCalibrationEnable),
    .lowPowerBackgroundEnable(lowPowerBackgroundEnable), .manualSpareControl(manualSpareControl),
    .statusPinSelect(statusPinSelect), .channelData(channelData), .corePowerDown(corePowerDown),
    .coreCalibrating(coreCalibrating), .inputSourceMap(inputSourceMap), .foregroundBusy(foregroundBusy),
    .spareCalibratedFlag(spareCalibratedFlag), .calibrationStatusPin(calibrationStatusPin));

// File: bench/sys_ctrl_model.sv
module sys_ctrl_model (
    input  wire logic clk,
    input  wire logic trigRequest,
    input  wire logic statusPin,
    output logic      trigPin,
    output int        doneCount
);
    timeunit 1ns;
    timeprecision 1ns;
    logic lastStat;
    initial
    begin
        trigPin = 1'b0;
        doneCount = 0;
        lastStat = 1'b0;
    end
    // Trigger pin moves only just after an edge, never glitching between them
    always @(posedge clk)
        trigPin <= trigRequest;
    // Count rising edges on the status pin, whether it reports spare or foreground completion
    always @(posedge clk)
    begin
        lastStat <= statusPin;
        if (statusPin && !lastStat)
            doneCount <= doneCount + 1;
    end
endmodule // sys_ctrl_model

// File: bench/adc_calibration_sequencer_tb.sv
module adc_calibration_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst_n, pinSel, softTrig, trigReq, bgEn, lpEn, manual, statSel, osOne, osCont, wrEn, rdEn;
    logic [7:0]  sleepIv, wakeSt, wrData, rdData;
    logic [14:0] addr;
    logic [71:0] samples;
    logic [47:0] chData;
    logic [5:0]  pwrDn, calBusy;
    logic [11:0] srcMap, mapHold;
    logic        trigPin, fgBusy, spFlag, statPin;
    int          fails, n_checks, doneCount, n;
    // ----------------------------------------
    // Design and far-side controller
    // ----------------------------------------
    adc_calibration_sequencer #(.FG_CAL_CYCLES(20), .BG_CAL_CYCLES(20), .SLEEP_UNIT_CYCLES(2), .WAKE_UNIT_CYCLES(2))
    adc_calibration_sequencer_i (.clk(clk), .rst_n(rst_n), .triggerPinSelect(pinSel), .softwareCalibrationTrigger(softTrig),
        .calibrationTriggerPin(trigPin), .backgroundCalibrationEnable(bgEn), .lowPowerBackgroundEnable(lpEn),
        .manualSpareControl(manual), .spareSleepInterval(sleepIv), .spareWakeSettleTime(wakeSt), .statusPinSelect(statSel),
        .oneShotOffsetCalibration(osOne), .continuousOffsetCalibration(osCont), .regWrEn(wrEn), .regRdEn(rdEn),
        .regAddr(addr), .regWrData(wrData), .regRdData(rdData), .coreSamples(samples), .offsetEstimate(48'h0),
        .channelData(chData), .corePowerDown(pwrDn), .coreCalibrating(calBusy), .inputSourceMap(srcMap),
        .foregroundBusy(fgBusy), .spareCalibratedFlag(spFlag), .calibrationStatusPin(statPin));
    sys_ctrl_model sys_ctrl_model_i (.clk(clk), .trigRequest(trigReq), .statusPin(statPin), .trigPin(trigPin),
        .doneCount(doneCount));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #2;
    endtask
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        if (fails == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic regWr(input logic [14:0] a, input logic [7:0] d);
        addr = a;
        wrData = d;
        wrEn = 1'b1;
        tick(1);
        wrEn = 1'b0;
        tick(1);
    endtask
    task automatic regRd(input logic [14:0] a, input logic [7:0] exp);
        addr = a;
        rdEn = 1'b1;
        tick(1);
        rdEn = 1'b0;
        chk({40'h0, rdData}, {40'h0, exp});
        tick(1);
    endtask
    // Bounded wait on busy (0), spare flag (1) or both spares asleep (2)
    task automatic waitOn(input int w, input logic lvl);
        int k;
        k = 0;
        while ((w == 0 ? fgBusy : w == 1 ? spFlag : $countones(pwrDn) == 2) !== lvl && k < 5000)
        begin
            tick(1);
            k++;
        end
        if (k >= 5000)
        begin
            fails++;
            complete_run();
        end
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic scnReset();
        waitOn(0, 1'b0);
        chk({36'h0, srcMap}, {36'h0, 3'h5, 3'h4, 3'h1, 3'h0});
        regRd(adc_cal_pkg::ADDR_CORE_SRC_DLY, adc_cal_pkg::RST_CORE_SRC_DLY);
        // Offset trims are only read by this test, though the host side can write them too
        regRd(adc_cal_pkg::ADDR_OFS_TRIM + 15'h2, 8'h80);
        regRd(15'h0050, adc_cal_pkg::READ_ZERO);
        regWr(adc_cal_pkg::ADDR_GAIN_TRIM + 15'h3, 8'h5A);
        regRd(adc_cal_pkg::ADDR_GAIN_TRIM + 15'h3, 8'h5A);
        regWr(adc_cal_pkg::ADDR_CORE_SRC_DLY, 8'h1F);
        regWr(adc_cal_pkg::ADDR_OUTPUT_MUX_SWITCH_DELAY, 8'h1E);
        regRd(adc_cal_pkg::ADDR_OUTPUT_MUX_SWITCH_DELAY, 8'h1E);
    endtask
    // Software then pin trigger; the pin path is resynchronised inside
    task automatic scnForeground();
        chk(chData, {12'h655, 12'h544, 12'h211, 12'h100});
        softTrig = 1'b1;
        waitOn(0, 1'b1);
        tick(1);
        chk(chData, {4{adc_cal_pkg::MID_SCALE_CODE}});
        waitOn(0, 1'b0);
        softTrig = 1'b0;
        pinSel = 1'b1;
        trigReq = 1'b1;
        waitOn(0, 1'b1);
        waitOn(0, 1'b0);
        trigReq = 1'b0;
        pinSel = 1'b0;
        tick(2);
        chk(chData, {12'h655, 12'h544, 12'h211, 12'h100});
    endtask
    task automatic scnBackground();
        // Earlier foreground-done edges on the pin are not spare completions
        n = doneCount;
        statSel = 1'b1;
        softTrig = 1'b1;
        bgEn = 1'b1;
        waitOn(1, 1'b1);
        tick(1);
        chk({47'h0, statPin}, 48'h1);
        waitOn(1, 1'b0);
        tick(34);
        chk({47'h0, srcMap[2:0] == 3'h2 || srcMap[5:3] == 3'h2}, 48'h1);
        chk(doneCount - n, 1);
    endtask
    // Automatic low power: sleep 3 units of 2, wake settle 2 units of 2
    task automatic scnLowPower();
        sleepIv = 8'h03;
        wakeSt = 8'h02;
        lpEn = 1'b1;
        waitOn(2, 1'b1);
        for (n = 0; $countones(pwrDn) == 2 && n < 100; n++)
            tick(1);
        chk({47'h0, n >= 6 && n <= 7}, 48'h1);
        for (n = 0; calBusy == 6'h00 && n < 100; n++)
            tick(1);
        chk({47'h0, n >= 4 && n <= 5}, 48'h1);
        // Manual control: a low trigger holds the calibrated spare unswapped
        manual = 1'b1;
        softTrig = 1'b0;
        waitOn(1, 1'b1);
        mapHold = srcMap;
        tick(40);
        chk({36'h0, srcMap}, {36'h0, mapHold});
        softTrig = 1'b1;
        waitOn(1, 1'b0);
        tick(34);
        chk({47'h0, srcMap != mapHold}, 48'h1);
        tick(20);
        chk({47'h0, $countones(pwrDn) == 2}, 48'h1);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial
    begin
        {rst_n, pinSel, softTrig, trigReq, bgEn, lpEn, manual, statSel, osOne, osCont, wrEn, rdEn} = 12'h000;
        {sleepIv, wakeSt, wrData, addr} = 39'h0;
        samples = {12'h655, 12'h544, 12'h433, 12'h322, 12'h211, 12'h100};
        fails = 0;
        n_checks = 0;
        tick(12);
        rst_n = 1'b1;
        scnReset();
        scnForeground();
        scnBackground();
        scnLowPower();
        complete_run();
    end
endmodule // adc_calibration_sequencer_tb
